// file: axh_pkg.sv
/*
 * Package for the axis homing sequencer: register map, reset values,
 * homing method codes, states and trigger selectors.
 * Assumes a 32-bit classic Wishbone register bus and 8-bit signed method codes.
 */
package axh_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_METHOD = 8'h04;
	localparam logic [7:0] REG_AUTO = 8'h08;
	localparam logic [7:0] REG_ACCEL = 8'h0c;
	localparam logic [7:0] REG_OFFSET = 8'h10;
	localparam logic [7:0] REG_SPEED1 = 8'h14;
	localparam logic [7:0] REG_SPEED2 = 8'h18;
	localparam logic [7:0] REG_STATE = 8'h1c;
	localparam logic [7:0] REG_PFB = 8'h20;
	localparam logic [7:0] REG_LATCH = 8'h24;
	localparam logic [7:0] REG_ADJUST = 8'h28;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_ACCEL = 32'h0000_0064;
	localparam logic [31:0] RST_SPEED1 = 32'h0000_1000;
	localparam logic [31:0] RST_SPEED2 = 32'h0000_0100;
	localparam logic [7:0] RST_METHOD = 8'h01;

	// ****************************************
	// Method codes
	// ****************************************
	localparam logic signed [7:0] M_STD1_LO = 8'sh01;
	localparam logic signed [7:0] M_STD1_HI = 8'sh0e;
	localparam logic signed [7:0] M_SW_LO = 8'sh11;
	localparam logic signed [7:0] M_SW_HI = 8'sh1e;
	localparam logic signed [7:0] M_IDX_NEG = 8'sh21;
	localparam logic signed [7:0] M_IDX_POS = 8'sh22;
	localparam logic signed [7:0] M_HERE = 8'sh23;
	localparam logic signed [7:0] M_EDGE_A = 8'sh18;
	localparam logic signed [7:0] M_EDGE_B = 8'sh1c;
	localparam logic signed [7:0] M_REV_A = -8'sh18;
	localparam logic signed [7:0] M_REV_B = -8'sh1c;
	localparam int RES_N = 13;
	localparam int ENC_N = 10;
	localparam logic signed [7:0] RES_IDX [RES_N] = '{-8'sh08, -8'sh0c, -8'sh21, -8'sh22, -8'sh28,
		-8'sh2c, -8'sh41, -8'sh42, -8'sh61, -8'sh62, 8'sh21, 8'sh22, 8'sh01};
	localparam logic signed [7:0] ENC_IDX [ENC_N] = '{8'sh21, -8'sh09, -8'sh0a, -8'sh0d, -8'sh0e,
		-8'sh22, -8'sh41, -8'sh42, -8'sh61, -8'sh62};

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {HS_IDLE, HS_SEARCH, HS_REVERSE, HS_TRIGGER, HS_HALT,
		HS_DONE, HS_ABORT, HS_FAULT} axh_state_t;
	typedef enum logic [2:0] {CL_INDEX, CL_EDGE, CL_EDGE_REV, CL_SWITCH, CL_HERE,
		CL_BAD} axh_cls_t;
	typedef enum logic [1:0] {TG_IDX, TG_HOME, TG_LIMP, TG_LIMN} axh_trg_t;
	typedef enum logic [1:0] {END_DONE, END_ABORT, END_FAULT} axh_end_t;

endpackage

// file: axh_ramp_if.sv
/*
 * Carrier between the sequencer and its velocity ramp.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface axh_ramp_if;
	logic signed [31:0] target;
	logic [31:0] step;
	logic signed [31:0] cur;
	logic settled;
	modport ctrl (output target, output step, input cur, input settled);
	modport ramp (input target, input step, output cur, output settled);
endinterface

// file: axh_ramp.sv
/*
 * Velocity ramp: moves the velocity command toward a target by at most
 * one step per clock, the same step for speeding up and slowing down.
 * Assumes step is nonzero whenever the target differs from the present value.
 */
`timescale 1ns/1ps
module axh_ramp (
	input wire logic clk_i,
	input wire logic rst_i,
	axh_ramp_if.ramp rif
);
	logic signed [31:0] cur_r;
	logic signed [32:0] diff;

	assign diff = {rif.target[31], rif.target} - {cur_r[31], cur_r};
	assign rif.cur = cur_r;
	assign rif.settled = (cur_r == rif.target);

	// ****************************************
	// Ramp
	// ****************************************
	// one rate both ways
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_r <= axh_pkg::RST_ZERO;
		end else if (diff > $signed({1'b0, rif.step})) begin
			cur_r <= cur_r + $signed(rif.step);
		end else if (diff < -$signed({1'b0, rif.step})) begin
			cur_r <= cur_r - $signed(rif.step);
		end else begin
			cur_r <= rif.target;
		end
	end
endmodule

// file: axh_homing_seq.sv
/*
 * Axis homing sequencer top: Wishbone register file, switch and feedback
 * synchronisers, homing state machine and home reference latch.
 * Assumes switch and feedback inputs are asynchronous and held for several
 * clocks; the velocity command output feeds a downstream velocity loop.
 */
`timescale 1ns/1ps
module axh_homing_seq #(
	parameter int ANG_W = 16,
	parameter logic AUTO_HOME_RST = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic limit_pos_i,
	input wire logic limit_neg_i,
	input wire logic home_switch_i,
	input wire logic hard_stop_i,
	input wire logic fb_is_resolver_i,
	input wire logic [ANG_W-1:0] motor_mechanical_angle_i,
	input wire logic [ANG_W-1:0] single_turn_position_i,
	input wire logic [31:0] position_feedback_counts_i,
	output logic [31:0] vel_cmd_o,
	output logic homing_active_o,
	output logic homed_o,
	output logic [31:0] home_adjust_o
);
	localparam int SW = 5 + 2 * ANG_W + 32;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] abs32(input logic signed [31:0] v);
		return v[31] ? 32'(-v) : 32'(v);
	endfunction

	// Zero crossing in either direction, so a fast axis cannot skip it
	function automatic logic zero_cross(input logic [ANG_W-1:0] c, input logic [ANG_W-1:0] p);
		logic [1:0] cq;
		logic [1:0] pq;
		cq = c[ANG_W-1 -: 2];
		pq = p[ANG_W-1 -: 2];
		return (c == '0) || (cq == 2'h0 && pq == 2'h3) || (cq == 2'h3 && pq == 2'h0);
	endfunction

	function automatic axh_pkg::axh_cls_t cls_of(input logic signed [7:0] m, input logic res);
		axh_pkg::axh_cls_t c;
		c = axh_pkg::CL_BAD;
		if (m == axh_pkg::M_HERE) begin
			c = axh_pkg::CL_HERE;
		end else if (m == axh_pkg::M_EDGE_A || m == axh_pkg::M_EDGE_B) begin
			c = axh_pkg::CL_EDGE;
		end else if (m == axh_pkg::M_REV_A || m == axh_pkg::M_REV_B) begin
			c = axh_pkg::CL_EDGE_REV;
		end else if (m >= axh_pkg::M_SW_LO && m <= axh_pkg::M_SW_HI) begin
			c = axh_pkg::CL_SWITCH;
		end else if ((m >= axh_pkg::M_STD1_LO && m <= axh_pkg::M_STD1_HI) ||
			m == axh_pkg::M_IDX_NEG || m == axh_pkg::M_IDX_POS) begin
			c = axh_pkg::CL_INDEX;
		end else if (res) begin
			for (int i = 0; i < axh_pkg::RES_N; i++) begin
				if (m == axh_pkg::RES_IDX[i]) begin
					c = axh_pkg::CL_INDEX;
				end
			end
		end else begin
			for (int i = 0; i < axh_pkg::ENC_N; i++) begin
				if (m == axh_pkg::ENC_IDX[i]) begin
					c = axh_pkg::CL_INDEX;
				end
			end
		end
		return c;
	endfunction

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [SW-1:0] sy1_r;
	logic [SW-1:0] sy2_r;
	always_ff @(posedge clk_i) begin
		sy1_r <= {limit_pos_i, limit_neg_i, home_switch_i, hard_stop_i, fb_is_resolver_i,
			motor_mechanical_angle_i, single_turn_position_i, position_feedback_counts_i};
		sy2_r <= sy1_r;
	end

	logic lim_p;
	logic lim_n;
	logic home_s;
	logic hard_s;
	logic res_s;
	logic [ANG_W-1:0] ang_s;
	logic [ANG_W-1:0] st_s;
	logic [31:0] pfb_s;
	assign {lim_p, lim_n, home_s, hard_s, res_s, ang_s, st_s, pfb_s} = sy2_r;

	logic home_p_r;
	logic lim_p_r;
	logic lim_n_r;
	logic hard_p_r;
	logic [ANG_W-1:0] ang_p_r;
	logic [ANG_W-1:0] st_p_r;
	always_ff @(posedge clk_i) begin
		home_p_r <= home_s;
		lim_p_r <= lim_p;
		lim_n_r <= lim_n;
		hard_p_r <= hard_s;
		ang_p_r <= ang_s;
		st_p_r <= st_s;
	end

	// ****************************************
	// Register file
	// ****************************************
	logic [31:0] cmd_r;
	logic [7:0] method_r;
	logic auto_r;
	logic [31:0] acc_r;
	logic [31:0] off_r;
	logic [31:0] spd1_r;
	logic [31:0] spd2_r;
	logic [31:0] latch_r;
	logic [31:0] adj_r;
	logic ack_r;
	logic [31:0] dat_r;
	axh_pkg::axh_state_t state_r;
	axh_ramp_if rif ();

	logic req;
	logic wr;
	logic wr_cmd;
	logic [31:0] cmd_val;
	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr = req && wb_we_i;
	assign wr_cmd = wr && wb_adr_i == axh_pkg::REG_CMD;
	assign cmd_val = merge(cmd_r, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_r <= axh_pkg::RST_ZERO;
			method_r <= axh_pkg::RST_METHOD;
			auto_r <= AUTO_HOME_RST;
			acc_r <= axh_pkg::RST_ACCEL;
			off_r <= axh_pkg::RST_ZERO;
			spd1_r <= axh_pkg::RST_SPEED1;
			spd2_r <= axh_pkg::RST_SPEED2;
		end else if (wr) begin
			if (wb_adr_i == axh_pkg::REG_CMD) begin
				cmd_r <= cmd_val;
			end else if (wb_adr_i == axh_pkg::REG_METHOD && wb_sel_i[0]) begin
				method_r <= wb_dat_i[7:0];
			end else if (wb_adr_i == axh_pkg::REG_AUTO && wb_sel_i[0]) begin
				auto_r <= wb_dat_i[0];
			end else if (wb_adr_i == axh_pkg::REG_ACCEL) begin
				acc_r <= merge(acc_r, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == axh_pkg::REG_OFFSET) begin
				off_r <= merge(off_r, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == axh_pkg::REG_SPEED1) begin
				spd1_r <= merge(spd1_r, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == axh_pkg::REG_SPEED2) begin
				spd2_r <= merge(spd2_r, wb_dat_i, wb_sel_i);
			end
		end
	end

	// Answer every access in one cycle; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= axh_pkg::RST_ZERO;
		end else begin
			ack_r <= req;
			dat_r <= axh_pkg::RST_ZERO;
			if (req && !wb_we_i) begin
				if (wb_adr_i == axh_pkg::REG_CMD) begin
					dat_r <= cmd_r;
				end else if (wb_adr_i == axh_pkg::REG_METHOD) begin
					dat_r <= {{24{method_r[7]}}, method_r};
				end else if (wb_adr_i == axh_pkg::REG_AUTO) begin
					dat_r <= {31'h0, auto_r};
				end else if (wb_adr_i == axh_pkg::REG_ACCEL) begin
					dat_r <= acc_r;
				end else if (wb_adr_i == axh_pkg::REG_OFFSET) begin
					dat_r <= off_r;
				end else if (wb_adr_i == axh_pkg::REG_SPEED1) begin
					dat_r <= spd1_r;
				end else if (wb_adr_i == axh_pkg::REG_SPEED2) begin
					dat_r <= spd2_r;
				end else if (wb_adr_i == axh_pkg::REG_STATE) begin
					dat_r <= {28'h0, state_r};
				end else if (wb_adr_i == axh_pkg::REG_PFB) begin
					dat_r <= pfb_s;
				end else if (wb_adr_i == axh_pkg::REG_LATCH) begin
					dat_r <= latch_r;
				end else if (wb_adr_i == axh_pkg::REG_ADJUST) begin
					dat_r <= adj_r;
				end
			end
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// ****************************************
	// Events
	// ****************************************
	logic auto_done_r;
	logic dir_r;
	axh_pkg::axh_cls_t cls_r;
	axh_pkg::axh_trg_t trg_r;
	axh_pkg::axh_end_t end_r;
	logic [31:0] acc_s;
	logic [31:0] s1_s;
	logic [31:0] s2_s;

	logic idle;
	logic busy;
	logic start;
	logic stop;
	logic idx_hit;
	logic lim_hit;
	logic home_rise;
	logic trg_ev;
	logic hit;
	axh_pkg::axh_cls_t cls_new;

	assign idle = state_r == axh_pkg::HS_IDLE || state_r == axh_pkg::HS_DONE ||
		state_r == axh_pkg::HS_ABORT || state_r == axh_pkg::HS_FAULT;
	assign busy = state_r == axh_pkg::HS_SEARCH || state_r == axh_pkg::HS_REVERSE ||
		state_r == axh_pkg::HS_TRIGGER;
	// start by command or once after reset
	assign start = idle && ((wr_cmd && cmd_val != axh_pkg::RST_ZERO) || (auto_r && !auto_done_r));
	assign stop = busy && wr_cmd && cmd_val == axh_pkg::RST_ZERO;
	assign idx_hit = res_s ? zero_cross(ang_s, ang_p_r) : zero_cross(st_s, st_p_r);
	assign lim_hit = dir_r ? lim_p : lim_n;
	assign home_rise = home_s && !home_p_r;
	assign cls_new = cls_of(method_r, res_s);
	always_comb begin
		case (trg_r)
			axh_pkg::TG_IDX: trg_ev = idx_hit;
			axh_pkg::TG_HOME: trg_ev = !home_s && home_p_r;
			axh_pkg::TG_LIMP: trg_ev = !lim_p && lim_p_r;
			default: trg_ev = !lim_n && lim_n_r;
		endcase
	end
	assign hit = (state_r == axh_pkg::HS_SEARCH && !stop && ((cls_r == axh_pkg::CL_INDEX && idx_hit) ||
		(cls_r == axh_pkg::CL_EDGE && home_rise))) ||
		(state_r == axh_pkg::HS_TRIGGER && !stop && trg_ev) ||
		(start && cls_new == axh_pkg::CL_HERE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_done_r <= 1'b0;
			acc_s <= axh_pkg::RST_ACCEL;
			s1_s <= axh_pkg::RST_ZERO;
			s2_s <= axh_pkg::RST_ZERO;
			cls_r <= axh_pkg::CL_BAD;
		end else begin
			auto_done_r <= 1'b1;
			// Speeds frozen per run so a mid-run write cannot jolt the axis
			if (start) begin
				acc_s <= acc_r;
				s1_s <= {1'b0, spd1_r[30:0]};
				s2_s <= {1'b0, spd2_r[30:0]};
				cls_r <= cls_new;
			end
		end
	end

	// ****************************************
	// Homing state machine
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= axh_pkg::HS_IDLE;
			dir_r <= 1'b0;
			trg_r <= axh_pkg::TG_IDX;
			end_r <= axh_pkg::END_DONE;
		end else if (hit) begin
			state_r <= axh_pkg::HS_HALT;
			end_r <= axh_pkg::END_DONE;
		end else if (stop) begin
			state_r <= axh_pkg::HS_HALT;
			end_r <= axh_pkg::END_ABORT;
		end else begin
			case (state_r)
				axh_pkg::HS_SEARCH: begin
					if (cls_r == axh_pkg::CL_INDEX && (lim_hit || hard_s)) begin
						state_r <= axh_pkg::HS_REVERSE;
						trg_r <= axh_pkg::TG_IDX;
						dir_r <= !dir_r;
					end else if (cls_r == axh_pkg::CL_EDGE_REV && home_rise) begin
						state_r <= axh_pkg::HS_REVERSE;
						trg_r <= axh_pkg::TG_HOME;
						dir_r <= !dir_r;
					end else if (cls_r == axh_pkg::CL_SWITCH && (home_rise || lim_hit)) begin
						state_r <= axh_pkg::HS_REVERSE;
						trg_r <= home_rise ? axh_pkg::TG_HOME : (dir_r ? axh_pkg::TG_LIMP : axh_pkg::TG_LIMN);
						dir_r <= !dir_r;
					end else if (lim_hit || hard_s) begin
						state_r <= axh_pkg::HS_HALT;
						end_r <= axh_pkg::END_FAULT;
					end
				end
				axh_pkg::HS_REVERSE: begin
					if (rif.settled) begin
						state_r <= axh_pkg::HS_TRIGGER;
					end
				end
				axh_pkg::HS_TRIGGER: begin
					// Hard stop has no side: only a fresh contact after reversal is a fault
					if (lim_hit || (hard_s && !hard_p_r)) begin
						state_r <= axh_pkg::HS_HALT;
						end_r <= axh_pkg::END_FAULT;
					end
				end
				axh_pkg::HS_HALT: begin
					if (rif.settled) begin
						state_r <= end_r == axh_pkg::END_DONE ? axh_pkg::HS_DONE :
							(end_r == axh_pkg::END_ABORT ? axh_pkg::HS_ABORT : axh_pkg::HS_FAULT);
					end
				end
				default: begin
					if (start) begin
						state_r <= cls_new == axh_pkg::CL_BAD ? axh_pkg::HS_FAULT : axh_pkg::HS_SEARCH;
						dir_r <= !method_r[0];
					end
				end
			endcase
		end
	end

	// ****************************************
	// Home latch and outputs
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_r <= axh_pkg::RST_ZERO;
			adj_r <= axh_pkg::RST_ZERO;
			homed_o <= 1'b0;
			homing_active_o <= 1'b0;
		end else begin
			// homed position = feedback + adjust
			if (hit) begin
				latch_r <= pfb_s;
				adj_r <= off_r - pfb_s;
			end
			if (start) begin
				homed_o <= 1'b0;
			end else if (state_r == axh_pkg::HS_HALT && rif.settled && end_r == axh_pkg::END_DONE) begin
				homed_o <= 1'b1;
			end
			homing_active_o <= !idle;
		end
	end
	assign home_adjust_o = adj_r;

	// ****************************************
	// Velocity target and ramp
	// ****************************************
	always_comb begin
		case (state_r)
			axh_pkg::HS_SEARCH: rif.target = dir_r ? $signed(s1_s) : -$signed(s1_s);
			axh_pkg::HS_TRIGGER: rif.target = dir_r ? $signed(s2_s) : -$signed(s2_s);
			default: rif.target = axh_pkg::RST_ZERO;
		endcase
	end
	assign rif.step = acc_s;
	assign vel_cmd_o = rif.cur;
	axh_ramp u_ramp (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rif(rif)
	);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	a_start_run: assert property (wr_cmd && cmd_val != 32'h0 && idle && !hit |=>
		state_r == axh_pkg::HS_SEARCH || state_r == axh_pkg::HS_FAULT) else $error("no start");
	a_stop_zero: assert property (stop && !hit |=> state_r == axh_pkg::HS_HALT &&
		end_r == axh_pkg::END_ABORT) else $error("no stop");
	a_accel_step: assert property (homing_active_o |->
		abs32(rif.cur - $past(rif.cur)) <= acc_s) else $error("rate exceeded");
	a_search_speed: assert property (state_r == axh_pkg::HS_SEARCH |->
		abs32(rif.cur) <= s1_s) else $error("search too fast");
	a_trigger_speed: assert property (state_r == axh_pkg::HS_TRIGGER |->
		abs32(rif.cur) <= s2_s && (rif.cur == 0 || rif.cur[31] != dir_r)) else $error("bad trigger speed");
	a_home_offset: assert property (hit |=> adj_r == $past(off_r) - $past(pfb_s) &&
		latch_r == $past(pfb_s) ##[1:1000] homed_o) else $error("bad home");
	a_state_read: assert property (req && !wb_we_i && wb_adr_i == axh_pkg::REG_STATE |=>
		wb_dat_o[3:0] == $past(state_r)) else $error("bad state read");

	c_done: cover property (state_r == axh_pkg::HS_HALT ##1 state_r == axh_pkg::HS_DONE);
	c_reverse: cover property (state_r == axh_pkg::HS_REVERSE ##[1:1000] state_r == axh_pkg::HS_TRIGGER);
	c_abort: cover property (state_r == axh_pkg::HS_ABORT);
	c_fault: cover property (state_r == axh_pkg::HS_FAULT);
endmodule

// file: axh_motor_model.sv
/*
 * Far-side model: motor, feedback and switches of one axis.
 * Assumes vel_i is counts per clock and the axis starts mid-travel at reset.
 */
`timescale 1ns/1ps
module axh_motor_model #(
	parameter int ANG_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] vel_i,
	output logic lim_pos_o,
	output logic lim_neg_o,
	output logic home_o,
	output logic stop_o,
	output logic [ANG_W-1:0] ang_o,
	output logic [31:0] pos_o
);
	logic signed [31:0] pos_r;
	// ****************************************
	// Axis travel
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_r <= 32'sh0000_8000;
		end else begin
			pos_r <= pos_r + $signed(vel_i);
		end
	end
	assign ang_o = pos_r[ANG_W-1:0];
	assign pos_o = pos_r;
	// Switch windows; positive limit lies past the index so index runs never see it
	assign lim_pos_o = pos_r > 32'sh0001_4000;
	assign lim_neg_o = pos_r < 32'sh0000_7000;
	assign stop_o = pos_r < 32'sh0000_1000;
	assign home_o = (pos_r >= 32'sh0000_9000) && (pos_r <= 32'sh0000_b000);
endmodule

// file: axis_homing_sequencer_bench.sv
/*
 * Bench for the homing sequencer: Wishbone tasks, motor model, run checks.
 * Assumes the ack comes one cycle after the request is taken.
 */
`timescale 1ns/1ps
module axis_homing_sequencer_bench;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, res = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, v, d, lat, prev_v;
	logic ack, lp, ln, hm, hs, act, homed, act_auto;
	logic [15:0] ang;
	logic [31:0] pos, adj;
	int err_count = 0, comparisons = 0, cycles = 0;
	int minv, maxv, i;
	axh_homing_seq uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.limit_pos_i(lp), .limit_neg_i(ln), .home_switch_i(hm), .hard_stop_i(hs),
		.fb_is_resolver_i(res), .motor_mechanical_angle_i(ang), .single_turn_position_i(ang),
		.position_feedback_counts_i(pos), .vel_cmd_o(v), .homing_active_o(act), .homed_o(homed),
		.home_adjust_o(adj));
	// Second copy powers up with auto-home on; its bus stays idle
	axh_homing_seq #(.AUTO_HOME_RST(1'b1)) uut_auto (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(1'b0),
		.wb_stb_i(1'b0), .wb_we_i(1'b0), .wb_adr_i(8'h00), .wb_sel_i(4'h0), .wb_dat_i(32'h0), .wb_dat_o(),
		.wb_ack_o(), .limit_pos_i(lp), .limit_neg_i(ln), .home_switch_i(hm), .hard_stop_i(hs),
		.fb_is_resolver_i(res), .motor_mechanical_angle_i(ang), .single_turn_position_i(ang),
		.position_feedback_counts_i(pos), .vel_cmd_o(), .homing_active_o(act_auto), .homed_o(),
		.home_adjust_o());
	axh_motor_model model (.clk_i(clk_i), .rst_i(rst_i), .vel_i(v), .lim_pos_o(lp), .lim_neg_o(ln),
		.home_o(hm), .stop_o(hs), .ang_o(ang), .pos_o(pos));
	always #50 clk_i = ~clk_i;
	// ****************************************
	// Tasks
	// ****************************************
	task automatic test_done();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
		chk({31'h0, ($signed(got) >= lo) && ($signed(got) <= hi)}, 32'h1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= 1'b1;
		adr <= a;
		wdat <= x;
		do @(posedge clk_i); while (ack !== 1'b1);
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		@(posedge clk_i);
		cyc <= 1'b1;
		adr <= a;
		do @(posedge clk_i); while (ack !== 1'b1);
		x = rdat;
		cyc <= 1'b0;
	endtask
	task automatic wait_state(input axh_pkg::axh_state_t s);
		for (int n = 0; n < 3000; n++) begin
			rd(axh_pkg::REG_STATE, d);
			if (d === 32'(s)) break;
		end
		chk(d, 32'(s));
	endtask
	// Lowered speeds keep the index accurate and the run short
	task automatic run(input logic signed [7:0] m, input logic r, input axh_pkg::axh_state_t s);
		@(posedge clk_i);
		rst_i <= 1'b1;
		res <= r;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		minv = 0;
		maxv = 0;
		wr(axh_pkg::REG_METHOD, 32'(m));
		wr(axh_pkg::REG_ACCEL, 32'h4);
		wr(axh_pkg::REG_SPEED1, 32'h40);
		wr(axh_pkg::REG_SPEED2, 32'h10);
		wr(axh_pkg::REG_OFFSET, 32'h100);
		wr(axh_pkg::REG_CMD, 32'h1);
		wait_state(s);
		rd(axh_pkg::REG_LATCH, lat);
	endtask
	task automatic done_ok();
		chk({31'h0, homed}, 32'h1);
		chk({31'h0, act}, 32'h0);
		chk(adj, 32'h100 - lat);
	endtask
	// ****************************************
	// Monitor and timeout
	// ****************************************
	always @(posedge clk_i) begin
		if (!rst_i) begin
			chk_rng($signed(v) - $signed(prev_v), -4, 4);
			if ($signed(v) < minv) minv = $signed(v);
			if ($signed(v) > maxv) maxv = $signed(v);
		end
		prev_v = v;
		cycles++;
		if (cycles == 90000) begin
			err_count++;
			test_done();
		end
	end
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(axh_pkg::REG_METHOD, d);
		chk(d, 32'h1);
		rd(axh_pkg::REG_SPEED1, d);
		chk(d, axh_pkg::RST_SPEED1);
		rd(axh_pkg::REG_AUTO, d);
		chk(d, 32'h0);
		chk({31'h0, act_auto}, 32'h1);
		wr(axh_pkg::REG_STATE, 32'h3);
		rd(axh_pkg::REG_STATE, d);
		chk(d, 32'h0);
		rd(8'h2c, d);
		chk(d, 32'h0);
		for (i = 0; i < 2; i++) begin
			run(i ? -8'sh09 : 8'sh21, i == 0, axh_pkg::HS_DONE);
			chk(minv, -32'sh40);
			chk(maxv, 32'h10);
			chk_rng(lat, 32'hfff0, 32'h10080);
			done_ok();
		end
		run(-8'sh09, 1'b1, axh_pkg::HS_FAULT);
		run(8'sh0f, 1'b1, axh_pkg::HS_FAULT);
		run(8'sh23, 1'b1, axh_pkg::HS_DONE);
		chk(lat, 32'h8000);
		done_ok();
		run(8'sh18, 1'b1, axh_pkg::HS_DONE);
		chk(maxv, 32'h40);
		chk_rng(lat, 32'h8fc0, 32'h9200);
		done_ok();
		run(-8'sh18, 1'b1, axh_pkg::HS_DONE);
		chk(minv, -32'sh10);
		done_ok();
		run(8'sh21, 1'b1, axh_pkg::HS_SEARCH);
		chk({31'h0, act}, 32'h1);
		wr(axh_pkg::REG_CMD, 32'h0);
		wait_state(axh_pkg::HS_ABORT);
		chk(v, 32'h0);
		chk({31'h0, act}, 32'h0);
		chk({31'h0, homed}, 32'h0);
		test_done();
	end
endmodule
